// [rtl/sfc_top.sv]
// Purpose: Serial frame format and control registers with tx framer.
// Assumes: Avalon-MM slave, one wait state per access; pins sampled here.
// Notes: Standby input clears the registers and framers as reset does; the bus slave's ack_q and rdata_q clear on reset only.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sfc_top #(
  parameter int BAUD_DIV = 1
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic standby_i,
  input wire logic sub_mode_i,
  input wire logic subclk_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_n_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  output logic tx_empty_irq_o,
  output logic rx_full_irq_o,
  output logic rx_err_irq_o,
  output logic tx_done_irq_o
);

  logic clr;
  sfc_pkg::sfc_format_type fmt_q;
  sfc_pkg::sfc_ctrl_type ctl_q;
  logic [7:0] txhold_q, rxhold_q, tsr_q, rdata_q, flags;
  logic txe_q, rxf_q, ovr_q, frm_q, per_q;
  logic ack_q, req, wr_go, wr_lane;
  sfc_pkg::sfc_tx_state_type tx_state_q;
  logic [3:0] tx_cnt_q, tx_idx_q, tx_nbits;
  logic txd_q, tx_par_q, tx_bit, tx_load, tx_end;
  logic base_tick, tick;
  logic rxd_meta_q, rxd_sync_q, sck_meta_q, sck_sync_q, sck_prev_q;
  logic ext_rise, ext_fall, int_rise, int_fall, ser_rise, ser_fall;
  logic [2:0] ck_cnt_q;
  logic sck_q, ck_run, ck_toggle, parity_eff;
  logic rx_done, rx_ferr, rx_perr;
  logic [7:0] rx_data;
  sfc_pkg::sfc_rx_cfg_type rx_cfg;

  localparam int SFC_TXE_BIT = sfc_pkg::SFC_TXE_BIT;
  localparam sfc_pkg::sfc_tx_state_type SFC_TX_IDLE_C = sfc_pkg::SFC_TX_IDLE;

  // Standby clears like reset, except the bus slave's ack_q and rdata_q
  assign clr = sys_rst_i | standby_i;

  // ==========================================================================
  // Bus slave: one wait state, read data captured on the first cycle
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_go = avs_write_i & ack_q;
  assign wr_lane = wr_go & avs_byteenable_i[0];
  assign avs_readdata_o = {24'h000000, rdata_q};

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  assign flags = {txe_q, rxf_q, ovr_q, frm_q, per_q, tx_end, 2'b00};

  // Read mux; unmapped words read as zero
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (avs_read_i && !ack_q) begin
      if (hit(avs_address_i, sfc_pkg::SFC_FORMAT_OFS)) begin
        rdata_q <= fmt_q;
      end else if (hit(avs_address_i, sfc_pkg::SFC_CTRL_OFS)) begin
        rdata_q <= ctl_q;
      end else if (hit(avs_address_i, sfc_pkg::SFC_FLAGS_OFS)) begin
        rdata_q <= flags;
      end else if (hit(avs_address_i, sfc_pkg::SFC_TXHOLD_OFS)) begin
        rdata_q <= txhold_q;
      end else if (hit(avs_address_i, sfc_pkg::SFC_RXHOLD_OFS)) begin
        rdata_q <= rxhold_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Format and control registers
  always_ff @(posedge clock_i) begin
    if (clr) begin
      fmt_q <= sfc_pkg::SFC_FORMAT_RST;
      ctl_q <= sfc_pkg::SFC_CTRL_RST;
    end else if (wr_lane) begin
      if (hit(avs_address_i, sfc_pkg::SFC_FORMAT_OFS)) begin
        fmt_q <= avs_writedata_i[7:0];
      end else if (hit(avs_address_i, sfc_pkg::SFC_CTRL_OFS)) begin
        ctl_q <= avs_writedata_i[7:0];
      end
    end
  end

  // Transmit holding register
  always_ff @(posedge clock_i) begin
    if (clr) begin
      txhold_q <= sfc_pkg::SFC_TXHOLD_RST;
    end else if (wr_lane && hit(avs_address_i, sfc_pkg::SFC_TXHOLD_OFS)) begin
      txhold_q <= avs_writedata_i[7:0];
    end
  end

  // ==========================================================================
  // Transmit empty flag: set beats clear
  always_ff @(posedge clock_i) begin
    if (clr || !ctl_q.tx_enable) begin
      txe_q <= 1'b1;
    end else if (tx_load) begin
      txe_q <= 1'b1;
    end else if (wr_lane && hit(avs_address_i, sfc_pkg::SFC_TXHOLD_OFS)) begin
      txe_q <= 1'b0;
    end else if (wr_lane && hit(avs_address_i, sfc_pkg::SFC_FLAGS_OFS)
                 && !avs_writedata_i[SFC_TXE_BIT]) begin
      txe_q <= 1'b0;
    end
  end

  // Receive flags; a clear of rx_on leaves them alone
  always_ff @(posedge clock_i) begin
    if (clr) begin
      rxf_q <= 1'b0;
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      per_q <= 1'b0;
      rxhold_q <= sfc_pkg::SFC_RXHOLD_RST;
    end else begin
      if (wr_lane && hit(avs_address_i, sfc_pkg::SFC_FLAGS_OFS)) begin
        rxf_q <= rxf_q & avs_writedata_i[sfc_pkg::SFC_RXF_BIT];
        ovr_q <= ovr_q & avs_writedata_i[sfc_pkg::SFC_OVR_BIT];
        frm_q <= frm_q & avs_writedata_i[sfc_pkg::SFC_FRM_BIT];
        per_q <= per_q & avs_writedata_i[sfc_pkg::SFC_PAR_BIT];
      end
      if (rx_done) begin
        if (rxf_q) begin
          ovr_q <= 1'b1;
        end else begin
          rxf_q <= 1'b1;
          rxhold_q <= rx_data;
          frm_q <= rx_ferr;
          per_q <= rx_perr;
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt requests, level while flag and enable both stand
  assign tx_empty_irq_o = ctl_q.tx_empty_irq_en & txe_q;
  assign rx_full_irq_o = ctl_q.rx_irq_en & rxf_q;
  assign rx_err_irq_o = ctl_q.rx_irq_en & (ovr_q | frm_q | per_q);
  assign tx_done_irq_o = ctl_q.tx_done_irq_en & tx_end;

  // ==========================================================================
  // Clocking: baud source, external clock pin and internal serial clock
  sfc_baud #(
    .BAUD_DIV(BAUD_DIV)
  ) u_baud (
    .clock_i(clock_i),
    .sys_rst_i(clr),
    .src_sel_i({fmt_q.baud_src_sel_hi, fmt_q.baud_src_sel_lo}),
    .sub_mode_i(sub_mode_i),
    .subclk_i(subclk_i),
    .sample_tick_o(base_tick)
  );

  // Pin synchronisers; edge detect reads only the second stage onward
  always_ff @(posedge clock_i) begin
    rxd_meta_q <= rxd_i;
    rxd_sync_q <= rxd_meta_q;
    sck_meta_q <= sck_i;
    sck_sync_q <= sck_meta_q;
    sck_prev_q <= sck_sync_q;
  end
  assign ext_rise = sck_sync_q & ~sck_prev_q;
  assign ext_fall = ~sck_sync_q & sck_prev_q;

  // Async external clock runs at 16 times the bit rate
  assign tick = (!fmt_q.sync_mode_sel && ctl_q.sck_pin_cfg_hi) ? ext_rise : base_tick;

  // Internal clock: async bit-rate output, or sync clock while sending
  assign ck_run = fmt_q.sync_mode_sel ? (!ctl_q.sck_pin_cfg_hi && tx_state_q != SFC_TX_IDLE_C)
                : (!ctl_q.sck_pin_cfg_hi && ctl_q.sck_pin_cfg_lo);
  assign ck_toggle = ck_run & tick & (ck_cnt_q == sfc_pkg::SFC_SCK_HALF_LAST);
  assign int_fall = ck_toggle & sck_q;
  assign int_rise = ck_toggle & ~sck_q;
  assign ser_rise = ctl_q.sck_pin_cfg_hi ? ext_rise : int_rise;
  assign ser_fall = ctl_q.sck_pin_cfg_hi ? ext_fall : int_fall;

  always_ff @(posedge clock_i) begin
    if (clr || !ck_run) begin
      ck_cnt_q <= 3'h0;
      sck_q <= 1'b1;
    end else if (tick) begin
      ck_cnt_q <= ck_cnt_q + 3'h1;
      if (ck_toggle) begin
        sck_q <= ~sck_q;
      end
    end
  end

  assign sck_o = sck_q;
  assign sck_oe_n_o = ~((fmt_q.sync_mode_sel && !ctl_q.sck_pin_cfg_hi) ||
                        (!fmt_q.sync_mode_sel && ck_run));

  // ==========================================================================
  // Transmit framer
  // Parity follows the multiprocessor bit as written; sync never has parity
  assign parity_eff = !fmt_q.sync_mode_sel & fmt_q.multiproc_mode_en
                    & fmt_q.parity_on;
  assign tx_nbits = (!fmt_q.sync_mode_sel && fmt_q.char7_sel) ? 4'h7 : 4'h8;
  assign tx_load = ctl_q.tx_enable & !txe_q & (tx_state_q == SFC_TX_IDLE_C);
  assign tx_bit = tick & (tx_cnt_q == sfc_pkg::SFC_OVS_LAST);
  assign tx_end = (tx_state_q == SFC_TX_IDLE_C) & txe_q;

  always_ff @(posedge clock_i) begin
    if (clr || !ctl_q.tx_enable) begin
      tx_state_q <= sfc_pkg::SFC_TX_IDLE;
      tx_cnt_q <= 4'h0;
      tx_idx_q <= 4'h0;
      tsr_q <= 8'hFF;
      tx_par_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      if (tick) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      case (tx_state_q)
        sfc_pkg::SFC_TX_IDLE: begin
          if (tx_load) begin
            tsr_q <= txhold_q;
            tx_par_q <= (^(txhold_q & (fmt_q.char7_sel ? 8'h7F : 8'hFF)))
                        ^ fmt_q.parity_odd_sel;
            tx_cnt_q <= 4'h0;
            tx_idx_q <= 4'h0;
            if (fmt_q.sync_mode_sel) begin
              tx_state_q <= sfc_pkg::SFC_TX_DATA;
            end else begin
              txd_q <= 1'b0;
              tx_state_q <= sfc_pkg::SFC_TX_START;
            end
          end
        end
        sfc_pkg::SFC_TX_START: begin
          if (tx_bit) begin
            txd_q <= tsr_q[0];
            tsr_q <= {1'b1, tsr_q[7:1]};
            tx_idx_q <= 4'h1;
            tx_state_q <= sfc_pkg::SFC_TX_DATA;
          end
        end
        sfc_pkg::SFC_TX_DATA: begin
          if (fmt_q.sync_mode_sel) begin
            if (ser_fall && tx_idx_q != 4'h8) begin
              txd_q <= tsr_q[0];
              tsr_q <= {1'b1, tsr_q[7:1]};
              tx_idx_q <= tx_idx_q + 4'h1;
            end else if (ser_rise && tx_idx_q == 4'h8) begin
              tx_state_q <= sfc_pkg::SFC_TX_IDLE;
            end
          end else if (tx_bit) begin
            if (tx_idx_q == tx_nbits) begin
              txd_q <= parity_eff ? tx_par_q : 1'b1;
              tx_state_q <= parity_eff ? sfc_pkg::SFC_TX_PAR : sfc_pkg::SFC_TX_STOP1;
            end else begin
              txd_q <= tsr_q[0];
              tsr_q <= {1'b1, tsr_q[7:1]};
              tx_idx_q <= tx_idx_q + 4'h1;
            end
          end
        end
        sfc_pkg::SFC_TX_PAR: begin
          if (tx_bit) begin
            txd_q <= 1'b1;
            tx_state_q <= sfc_pkg::SFC_TX_STOP1;
          end
        end
        sfc_pkg::SFC_TX_STOP1: begin
          if (tx_bit) begin
            tx_state_q <= fmt_q.stop_bit_count_sel ? sfc_pkg::SFC_TX_STOP2
                        : sfc_pkg::SFC_TX_IDLE;
          end
        end
        default: begin
          if (tx_bit) begin
            tx_state_q <= sfc_pkg::SFC_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Released pin floats to the port function while transmit is off
  assign txd_o = ctl_q.tx_enable ? txd_q : 1'b1;
  assign txd_oe_n_o = ~ctl_q.tx_enable;

  // ==========================================================================
  // Receiver
  assign rx_cfg = '{sync_mode: fmt_q.sync_mode_sel, char7: fmt_q.char7_sel,
                    parity_en: parity_eff, parity_odd: fmt_q.parity_odd_sel};

  sfc_rx u_rx (
    .clock_i(clock_i),
    .sys_rst_i(clr),
    .enable_i(ctl_q.rx_on),
    .cfg_i(rx_cfg),
    .sample_tick_i(tick),
    .ser_rise_i(ser_rise),
    .rxd_i(rxd_sync_q),
    .done_o(rx_done),
    .data_o(rx_data),
    .frame_err_o(rx_ferr),
    .parity_err_o(rx_perr)
  );

endmodule : sfc_top
`default_nettype wire

// [rtl/sfc_pkg.sv]
// Purpose: Shared constants and types for the serial frame and control block.
// Assumes: Avalon-MM slave with 32-bit data, 8-bit registers in the low byte.
// Notes: Offsets are byte addresses of aligned words.
package sfc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [4:0] SFC_FORMAT_OFS = 5'h00;
  localparam logic [4:0] SFC_CTRL_OFS = 5'h04;
  localparam logic [4:0] SFC_FLAGS_OFS = 5'h08;
  localparam logic [4:0] SFC_TXHOLD_OFS = 5'h0C;
  localparam logic [4:0] SFC_RXHOLD_OFS = 5'h10;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] SFC_FORMAT_RST = 8'h00;
  localparam logic [7:0] SFC_CTRL_RST = 8'h00;
  localparam logic [7:0] SFC_TXHOLD_RST = 8'hFF;
  localparam logic [7:0] SFC_RXHOLD_RST = 8'h00;

  // ==========================================================================
  // Field positions in the flags register
  localparam int SFC_TXE_BIT = 7;
  localparam int SFC_RXF_BIT = 6;
  localparam int SFC_OVR_BIT = 5;
  localparam int SFC_FRM_BIT = 4;
  localparam int SFC_PAR_BIT = 3;

  // ==========================================================================
  // Cycle counts
  localparam logic [3:0] SFC_OVS_LAST = 4'hF;  // 16 sample ticks per async bit
  localparam logic [3:0] SFC_HALF_LAST = 4'h7;  // Middle of the start bit
  localparam logic [2:0] SFC_SCK_HALF_LAST = 3'h7;  // 8 ticks per serial clock phase
  localparam logic [5:0] SFC_PRE16_LAST = 6'h0F;
  localparam logic [5:0] SFC_PRE64_LAST = 6'h3F;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic sync_mode_sel;
    logic char7_sel;
    logic parity_on;
    logic parity_odd_sel;
    logic stop_bit_count_sel;
    logic multiproc_mode_en;
    logic baud_src_sel_hi;
    logic baud_src_sel_lo;
  } sfc_format_type;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic rx_irq_en;
    logic tx_enable;
    logic rx_on;
    logic mproc_irq_en;
    logic tx_done_irq_en;
    logic sck_pin_cfg_hi;
    logic sck_pin_cfg_lo;
  } sfc_ctrl_type;

  // Framing seen by the receiver
  typedef struct packed {
    logic sync_mode;
    logic char7;
    logic parity_en;
    logic parity_odd;
  } sfc_rx_cfg_type;

  typedef enum logic [2:0] {
    SFC_TX_IDLE,
    SFC_TX_START,
    SFC_TX_DATA,
    SFC_TX_PAR,
    SFC_TX_STOP1,
    SFC_TX_STOP2
  } sfc_tx_state_type;

  typedef enum logic [2:0] {
    SFC_RX_IDLE,
    SFC_RX_START,
    SFC_RX_DATA,
    SFC_RX_PAR,
    SFC_RX_STOP
  } sfc_rx_state_type;

endpackage : sfc_pkg

// [rtl/sfc_baud.sv]
// Purpose: Baud generator source select and sample tick divider.
// Assumes: Subclock arrives asynchronously on a pin.
// Notes: Output is a one-cycle enable at 16 times the async bit rate.
`timescale 1ns/1ps
`default_nettype none
module sfc_baud #(
  parameter int BAUD_DIV = 1
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] src_sel_i,
  input wire logic sub_mode_i,
  input wire logic subclk_i,
  output logic sample_tick_o
);

  if (BAUD_DIV < 1 || BAUD_DIV > 256) begin : g_bad_div
    $error("BAUD_DIV must lie in 1..256");
  end

  logic sub_meta_q, sub_sync_q, sub_prev_q, sub_half_q;
  logic [5:0] pre_q;
  logic [7:0] div_q;
  logic sub_edge, src_tick;

  // ==========================================================================
  // Subclock synchroniser and edge detect
  always_ff @(posedge clock_i) begin
    sub_meta_q <= subclk_i;
    sub_sync_q <= sub_meta_q;
    sub_prev_q <= sub_sync_q;
  end
  assign sub_edge = sub_sync_q & ~sub_prev_q;

  // Halves the subclock; the halved rate is used only while sub_mode_i is low, sub_mode_i high takes every edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sub_half_q <= 1'b0;
    end else if (sub_edge) begin
      sub_half_q <= ~sub_half_q;
    end
  end

  // Free prescaler for the divided system clock taps
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pre_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  // Source select
  always_comb begin
    case (src_sel_i)
      2'b00: src_tick = 1'b1;
      2'b01: src_tick = sub_edge & (sub_mode_i | sub_half_q);
      2'b10: src_tick = (pre_q[3:0] == sfc_pkg::SFC_PRE16_LAST[3:0]);
      default: src_tick = (pre_q == sfc_pkg::SFC_PRE64_LAST);
    endcase
  end

  localparam logic [7:0] DIV_LAST = 8'(BAUD_DIV - 1);

  // Rate divider standing in for the bit-rate setting
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      div_q <= 8'h00;
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= 1'b0;
      if (src_tick) begin
        if (div_q == DIV_LAST) begin
          div_q <= 8'h00;
          sample_tick_o <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end
    end
  end

endmodule : sfc_baud
`default_nettype wire

// [rtl/sfc_rx.sv]
// Purpose: Receive framer for async and clocked synchronous modes.
// Assumes: rxd_i is already synchronised; ticks are one-cycle enables.
// Notes: Only the first stop bit is looked at.
`timescale 1ns/1ps
`default_nettype none
module sfc_rx (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire sfc_pkg::sfc_rx_cfg_type cfg_i,
  input wire logic sample_tick_i,
  input wire logic ser_rise_i,
  input wire logic rxd_i,
  output logic done_o,
  output logic [7:0] data_o,
  output logic frame_err_o,
  output logic parity_err_o
);

  sfc_pkg::sfc_rx_state_type state_q;
  logic [3:0] cnt_q, idx_q, nbits;
  logic [7:0] shr_q;
  logic par_q, sample;

  assign nbits = cfg_i.sync_mode ? 4'h8 : (cfg_i.char7 ? 4'h7 : 4'h8);
  // Mid-bit in async, serial clock rise in sync
  assign sample = cfg_i.sync_mode ? ser_rise_i
                : (sample_tick_i && cnt_q == sfc_pkg::SFC_OVS_LAST);

  // ==========================================================================
  // Framing state machine, LSB first
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !enable_i) begin
      state_q <= sfc_pkg::SFC_RX_IDLE;
      cnt_q <= 4'h0;
      idx_q <= 4'h0;
      shr_q <= 8'h00;
      par_q <= 1'b0;
      done_o <= 1'b0;
      data_o <= 8'h00;
      frame_err_o <= 1'b0;
      parity_err_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (sample_tick_i) begin
        cnt_q <= cnt_q + 4'h1;
      end
      case (state_q)
        sfc_pkg::SFC_RX_IDLE: begin
          cnt_q <= 4'h0;
          idx_q <= 4'h0;
          par_q <= cfg_i.parity_odd;
          if (cfg_i.sync_mode && ser_rise_i) begin
            shr_q <= {rxd_i, shr_q[7:1]};
            idx_q <= 4'h1;
            state_q <= sfc_pkg::SFC_RX_DATA;
          end else if (!cfg_i.sync_mode && !rxd_i) begin
            state_q <= sfc_pkg::SFC_RX_START;
          end
        end
        sfc_pkg::SFC_RX_START: begin
          if (sample_tick_i && cnt_q == sfc_pkg::SFC_HALF_LAST) begin
            cnt_q <= 4'h0;
            state_q <= rxd_i ? sfc_pkg::SFC_RX_IDLE : sfc_pkg::SFC_RX_DATA;
          end
        end
        sfc_pkg::SFC_RX_DATA: begin
          if (sample) begin
            shr_q <= {rxd_i, shr_q[7:1]};
            par_q <= par_q ^ rxd_i;
            idx_q <= idx_q + 4'h1;
            if (idx_q + 4'h1 == nbits) begin
              if (cfg_i.sync_mode) begin
                done_o <= 1'b1;
                data_o <= {rxd_i, shr_q[7:1]};
                frame_err_o <= 1'b0;
                parity_err_o <= 1'b0;
                state_q <= sfc_pkg::SFC_RX_IDLE;
              end else begin
                state_q <= cfg_i.parity_en ? sfc_pkg::SFC_RX_PAR : sfc_pkg::SFC_RX_STOP;
              end
            end
          end
        end
        sfc_pkg::SFC_RX_PAR: begin
          if (sample) begin
            par_q <= par_q ^ rxd_i;
            state_q <= sfc_pkg::SFC_RX_STOP;
          end
        end
        default: begin
          // Second stop bit is never waited for
          if (sample) begin
            done_o <= 1'b1;
            data_o <= cfg_i.char7 ? {1'b0, shr_q[7:1]} : shr_q;
            frame_err_o <= ~rxd_i;
            parity_err_o <= cfg_i.parity_en & par_q;
            state_q <= sfc_pkg::SFC_RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule : sfc_rx
`default_nettype wire

// [testbench/sfc_top_monitor.sv]
// Purpose: Port checker for sfc_top.
// Assumes: One clock, sync reset, byteenable held all ones.
// Notes: Bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module sfc_top_monitor (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic standby_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic txd_o,
  input wire logic txd_oe_n_o,
  input wire logic tx_empty_irq_o,
  input wire logic rx_full_irq_o,
  input wire logic rx_err_irq_o
);
  // ==========================================================================
  // Completed writes
  logic cw;
  logic tw;
  assign cw = avs_write_i && !avs_waitrequest_o && avs_address_i == sfc_pkg::SFC_CTRL_OFS;
  assign tw = avs_write_i && !avs_waitrequest_o && avs_address_i == sfc_pkg::SFC_TXHOLD_OFS;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_wait_one: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("stalled");
  chk_idle_nowait: assert property (
    !avs_read_i && !avs_write_i |-> !avs_waitrequest_o) else $error("idle wait");
  chk_stby_clear: assert property (
    standby_i |=> txd_oe_n_o && !tx_empty_irq_o && !rx_err_irq_o) else $error("standby");
  chk_tx_off: assert property (
    cw && !avs_writedata_i[5] |=> txd_oe_n_o && txd_o) else $error("tx pin kept");
  chk_tx_on: assert property (
    cw && avs_writedata_i[5] |=> !txd_oe_n_o) else $error("tx pin idle");
  chk_txirq_drop: assert property (
    cw && !avs_writedata_i[7] |=> !tx_empty_irq_o) else $error("tx irq kept");
  chk_rxirq_drop: assert property (
    cw && !avs_writedata_i[6] |=> !rx_full_irq_o && !rx_err_irq_o) else $error("rx irq kept");
  chk_tx_start: assert property (
    tw && !txd_oe_n_o && txd_o |-> ##[1:320] !txd_o) else $error("no start bit");
  cover property (cw && avs_writedata_i[5]);
  cover property ($rose(rx_err_irq_o));
  cover property ($rose(tx_empty_irq_o));
endmodule : sfc_top_monitor
bind sfc_top sfc_top_monitor u_mon (.clock_i, .sys_rst_i, .standby_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .txd_o, .txd_oe_n_o,
  .tx_empty_irq_o, .rx_full_irq_o, .rx_err_irq_o);
`default_nettype wire

// [testbench/sfc_peer.sv]
// Purpose: Remote serial peer on the tx and rx lines.
// Assumes: 16 clocks per bit.
// Notes: gap_o is stop time in bits, 4 when the line stays idle.
`timescale 1ns/1ps
`default_nettype none
module sfc_peer (
  input wire logic clock_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic [7:0] got_o,
  output logic [2:0] gap_o,
  output logic seen_o
);
  int n;
  // Frame decoder, samples mid bit
  initial begin
    rxd_o = 1'h1;
    seen_o = 1'h0;
    forever begin
      @(posedge clock_i);
      if (!txd_i) begin
        repeat (8) @(posedge clock_i);
        for (n = 0; n < 8; n++) begin
          repeat (16) @(posedge clock_i);
          got_o[n] = txd_i;
        end
        repeat (8) @(posedge clock_i); // Into the first stop bit
        n = 0;
        do begin @(posedge clock_i); n++; end while (txd_i && n < 64);
        gap_o = 3'(n / 16);
        seen_o = !seen_o;
      end
    end
  end
  // Sender; line idles high like a pulled-up wire
  task automatic send(input logic [7:0] b, input logic stp);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= 10'({stp, b, 1'h0}) >> i;
      repeat (16) @(posedge clock_i);
    end
    rxd_o <= 1'h1;
  endtask : send
endmodule : sfc_peer
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench for sfc_top.
// Assumes: BAUD_DIV 1 and system clock source.
// Notes: Requests rise after an edge and hold until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic standby_i = 1'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [4:0] adr = 5'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat, b0, b1, got;
  logic [31:0] rdo;
  logic wt, txd, oe, rxd, tirq, rirq, eirq, seen;
  logic [2:0] gap;
  int error_cnt = 0;
  int n_compared = 0;
  always #5 clock_i = !clock_i;
  sfc_top #(.BAUD_DIV(1)) uut (.clock_i, .sys_rst_i, .standby_i, .sub_mode_i(1'h0),
    .subclk_i(1'h0), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i({24'h000000, wd}), .avs_byteenable_i(4'hF), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wt), .rxd_i(rxd), .txd_o(txd), .txd_oe_n_o(oe), .sck_i(1'h1),
    .sck_o(), .sck_oe_n_o(), .tx_empty_irq_o(tirq), .rx_full_irq_o(rirq),
    .rx_err_irq_o(eirq), .tx_done_irq_o());
  sfc_peer peer (.clock_i, .txd_i(txd), .rxd_o(rxd), .got_o(got), .gap_o(gap), .seen_o(seen));
  // ==========================================================================
  // Bus and compare tasks
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clock_i); while (wt);
    rdat = rdo[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : acc
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [4:0] a, input logic [7:0] e, m);
    acc(1'h0, a, 8'h00);
    chk(n, e, rdat & m);
  endtask : rchk
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // Watchdog, far above the fewer than 2000 cycles needed
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    conclude();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(17));
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    rchk("ctrl", sfc_pkg::SFC_CTRL_OFS, 8'h00, 8'hFF);
    rchk("flags", sfc_pkg::SFC_FLAGS_OFS, 8'h84, 8'hFF);
    rchk("unmapped", 5'h14, 8'h00, 8'hFF);
    repeat (4) begin
      b0 = 8'($urandom);
      acc(1'h1, sfc_pkg::SFC_CTRL_OFS, b0);
      rchk("ctrl rw", sfc_pkg::SFC_CTRL_OFS, b0, 8'hFF);
    end
    acc(1'h1, sfc_pkg::SFC_CTRL_OFS, 8'hF0);
    standby_i <= 1'h1;
    @(posedge clock_i);
    standby_i <= 1'h0;
    rchk("ctrl stby", sfc_pkg::SFC_CTRL_OFS, 8'h00, 8'hFF);
    // Two chars back to back per stop setting
    for (int s = 0; s < 2; s++) begin
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      acc(1'h1, sfc_pkg::SFC_FORMAT_OFS, 8'(s * 8));
      acc(1'h1, sfc_pkg::SFC_CTRL_OFS, 8'hA0);
      acc(1'h1, sfc_pkg::SFC_TXHOLD_OFS, b0);
      acc(1'h1, sfc_pkg::SFC_TXHOLD_OFS, b1);
      @(seen);
      chk("tx data", b0, got);
      chk("stop bits", 8'(s + 1), 8'(gap));
      @(seen);
      chk("tx data2", b1, got);
      chk("tx irq", 8'h01, 8'(tirq));
    end
    acc(1'h1, sfc_pkg::SFC_CTRL_OFS, 8'h00);
    rchk("empty held", sfc_pkg::SFC_FLAGS_OFS, 8'h80, 8'h80);
    // Receive: two frames, second start right after first stop
    acc(1'h1, sfc_pkg::SFC_CTRL_OFS, 8'h50);
    fork
      begin peer.send(b0, 1'h1); peer.send(b1, 1'h1); end
    join_none
    for (int k = 0; k < 2; k++) begin
      wait (rirq);
      rchk("rx data", sfc_pkg::SFC_RXHOLD_OFS, k ? b1 : b0, 8'hFF);
      rchk("rx flags", sfc_pkg::SFC_FLAGS_OFS, 8'h40, 8'h78);
      acc(1'h1, sfc_pkg::SFC_FLAGS_OFS, 8'h00);
      @(negedge clock_i);
      chk("rx irq clr", 8'h00, 8'(rirq));
    end
    repeat (16) @(posedge clock_i);
    peer.send(b0, 1'h0);
    rchk("framing", sfc_pkg::SFC_FLAGS_OFS, 8'h10, 8'h10);
    acc(1'h1, sfc_pkg::SFC_CTRL_OFS, 8'h40);
    rchk("flag kept", sfc_pkg::SFC_FLAGS_OFS, 8'h10, 8'h10);
    chk("err irq", 8'h01, 8'(eirq));
    conclude();
  end
endmodule : tb
`default_nettype wire
